// ==== l3si_pkg.sv ====
// l3si_pkg: constants shared by the sram interface and its fifo
// assumes a 50 MHz system clock and one bank of synchronous srams
package l3si_pkg;
    localparam int L3SI_ADDR_W = 18;
    localparam int L3SI_DATA_W = 64;
    localparam int L3SI_FIFO_DEPTH = 8;
    localparam int L3SI_BEATS = 4;
    localparam logic [1:0] L3SI_MODE_DDR = 2'h0;
    localparam logic [1:0] L3SI_MODE_LW = 2'h1;
    localparam logic [1:0] L3SI_MODE_PB = 2'h2;
    // extra read cycles after the last beat, per mode
    localparam logic [1:0] L3SI_PB_XTRA = 2'h1;
    localparam logic [1:0] L3SI_LW_XTRA = 2'h0;
    // read-to-write turnaround cycles
    localparam logic [1:0] L3SI_PB_TURN = 2'h2;
    localparam logic [1:0] L3SI_LW_TURN = 2'h1;
    typedef enum logic [2:0] {
        L3SI_IDLE = 3'h0,
        L3SI_ADDR = 3'h1,
        L3SI_XTRA = 3'h3,
        L3SI_WAIT = 3'h2,
        L3SI_TURN = 3'h6
    } l3si_state_e;
endpackage

// ==== l3si_fifo.sv ====
// l3si_fifo: synchronous valid/ready fifo for read data
// assumes both sides on the same clock
module l3si_fifo import l3si_pkg::*; #(
    parameter int WIDTH = L3SI_DATA_W,
    parameter int DEPTH = L3SI_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("l3si_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        in_ready = !((wp_q[AW] != rp_q[AW]) &&
                     (wp_q[AW-1:0] == rp_q[AW-1:0]));
        out_valid = (wp_q != rp_q);
        out_data = mem_q[rp_q[AW-1:0]];
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==== l3si_ctrl.sv ====
// l3si_ctrl: sram side of a level-3 cache data store
// assumes the processor side issues whole-line requests and that the
// sram return clock arrives unrelated to clk_sys
// Function
// RQ1: ddr sram returns data on both edges of its return clock.
// RQ2: ddr sram makes its return clock independently of its input clock.
// RQ3: ddr mode issues two separate addresses per line, no burst continue.
// RQ4: ddr mode always selects double transfers.
// RQ5: late-write data follows the write command by one sram cycle.
// RQ6: late-write mode drives a new address for every beat.
// RQ7: late-write srams are pipelined register-register parts.
// RQ8: late-write sram commits queued write when the next write arrives.
// RQ9: late-write has no extra read cycle, one shorter turnaround.
// RQ10: control one is an active-low synchronous write strobe.
// RQ11: control zero is an active-low synchronous chip select.
// RQ12: odd return clock pins output, looped back to even inputs.
// RQ13: pipelined burst sram returns first data one cycle later.
// RQ14: pipelined burst srams are single-cycle-deselect parts.
// RQ15: pipelined burst mode drives a separate address per beat.
// RQ16: pipelined burst mode signals one extra read after the last.
// RQ17: tolerate early sram drive; keep own drivers off then.
// RQ18: every started read completes; no aborts.
// RQ19: exactly one bank, no bank select decoding.
// RQ20: sram address is 18 bits, 17 down to 0.
// RQ21: read data crosses from return clock into clk_sys safely.
module l3si_ctrl import l3si_pkg::*; #(
    parameter int ADDR_W = L3SI_ADDR_W,
    parameter int DATA_W = L3SI_DATA_W,
    parameter int DEPTH = L3SI_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // mode select, changed only while idle
    input wire logic [1:0] mode,
    // line request from the processor side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    // read data toward the processor side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DATA_W-1:0] rd_data,
    // sram pins
    output logic sram_output_clock,
    output logic [ADDR_W-1:0] sram_addr,
    output logic sram_control_zero,
    output logic sram_control_one,
    output logic sram_double_xfer,
    input wire logic [DATA_W-1:0] sram_data_bus_i,
    output logic [DATA_W-1:0] sram_data_bus_o,
    output logic sram_data_bus_oe_n,
    input wire logic sram_return_clock,
    output logic sram_return_clock_out
);
    initial begin
        if (ADDR_W != L3SI_ADDR_W || DEPTH < 2)
            $error("l3si_ctrl: unsupported parameters");
    end

    // sram clock is clk_sys/2; beats move on its rising half
    logic sclk_q, sclk_d;
    l3si_state_e st_q, st_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [1:0] beat_q, beat_d, cnt_q, cnt_d;
    logic wr_q, wr_d, lastrd_q, lastrd_d;
    logic cs_n_q, cs_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
    logic [DATA_W-1:0] wd_q, wd_d, pend_q, pend_d;
    logic pend_v_q, pend_v_d, rdy_q, rdy_d;
    logic sedge;
    logic [1:0] nbeat;
    logic [1:0] xtra, turn;

    // return clock sync and edge finding; first stage read only by second
    logic [2:0] rc_q;
    logic [DATA_W-1:0] cap_s1_q, cap_s2_q;
    logic [2:0] exp_q, exp_d;
    logic rd_issue;
    logic fifo_in_v, fifo_in_rdy;

    always_comb begin
        sclk_d = ~sclk_q;
        sedge = ~sclk_q;
        nbeat = (mode == L3SI_MODE_DDR) ? 2'h1 : 2'h3; // RQ3 RQ4
        xtra = (mode == L3SI_MODE_PB) ? L3SI_PB_XTRA : L3SI_LW_XTRA; // RQ9
        turn = (mode == L3SI_MODE_PB) ? L3SI_PB_TURN : L3SI_LW_TURN; // RQ9
        st_d = st_q;
        addr_d = addr_q;
        beat_d = beat_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        lastrd_d = lastrd_q;
        cs_n_d = cs_n_q;
        we_n_d = we_n_q;
        oe_n_d = 1'b1;
        wd_d = wd_q;
        pend_d = pend_q;
        pend_v_d = pend_v_q;
        rdy_d = 1'b0;
        exp_d = exp_q;
        rd_issue = 1'b0;
        if (sedge) begin
            // late-write data one sram cycle after its command
            if (pend_v_q) begin
                wd_d = pend_q; // RQ5
                oe_n_d = 1'b0;
                pend_v_d = 1'b0;
            end
            unique case (st_q)
                L3SI_IDLE: begin
                    cs_n_d = 1'b1;
                    we_n_d = 1'b1;
                    // a read after a read needs no turnaround
                    if (req_valid && fifo_in_rdy && exp_q == 3'h0 &&
                        !(req_write && lastrd_q)) begin
                        st_d = L3SI_ADDR;
                        wr_d = req_write;
                        addr_d = req_addr; // RQ19 RQ20
                        beat_d = 2'h0;
                        rdy_d = 1'b1;
                    end else if (req_valid && req_write && lastrd_q) begin
                        st_d = L3SI_TURN;
                        cnt_d = turn;
                    end
                end
                L3SI_ADDR: begin
                    cs_n_d = 1'b0; // RQ11
                    we_n_d = ~wr_q; // RQ10
                    if (wr_q) begin
                        pend_d = req_wdata;
                        pend_v_d = 1'b1;
                        if (mode == L3SI_MODE_PB) begin
                            wd_d = req_wdata;
                            oe_n_d = 1'b0;
                            pend_v_d = 1'b0;
                        end
                    end else begin
                        rd_issue = 1'b1;
                    end
                    // a fresh address per beat, never sram burst counting
                    if (beat_q != 2'h0)
                        addr_d = addr_q + 1'b1; // RQ6 RQ15 RQ3
                    beat_d = beat_q + 2'h1;
                    if (beat_q == nbeat) begin
                        lastrd_d = ~wr_q;
                        st_d = (!wr_q && xtra != 2'h0) ? L3SI_XTRA
                                                         : L3SI_IDLE;
                    end
                end
                L3SI_XTRA: begin
                    // hold read signalled so the last beat stays driven
                    cs_n_d = 1'b0; // RQ16
                    we_n_d = 1'b1;
                    st_d = L3SI_WAIT;
                end
                L3SI_WAIT: begin
                    cs_n_d = 1'b1;
                    st_d = L3SI_IDLE; // RQ18
                end
                L3SI_TURN: begin
                    // own drivers stay off while an sram may still drive
                    cs_n_d = 1'b1;
                    oe_n_d = 1'b1; // RQ17
                    if (cnt_q <= 2'h1) begin
                        lastrd_d = 1'b0;
                        st_d = L3SI_IDLE;
                    end else begin
                        cnt_d = cnt_q - 2'h1;
                    end
                end
                default: st_d = L3SI_IDLE;
            endcase
        end else begin
            oe_n_d = oe_n_q;
        end
        // every expected beat is counted off as it lands; a beat that meets a full fifo is lost
        // in one cycle an issue adds its beats (two in ddr) and a landing beat takes one off
        if (rd_issue)
            exp_d = exp_q + ((mode == L3SI_MODE_DDR) ? 3'h2 : 3'h1); // RQ1
        if (rc_q[2] != rc_q[1] && exp_q != 3'h0)
            exp_d = exp_d - 3'h1; // RQ18
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_q <= 1'b0;
            st_q <= L3SI_IDLE;
            addr_q <= '0;
            beat_q <= 2'h0;
            cnt_q <= 2'h0;
            wr_q <= 1'b0;
            lastrd_q <= 1'b0;
            cs_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            wd_q <= '0;
            pend_q <= '0;
            pend_v_q <= 1'b0;
            rdy_q <= 1'b0;
            exp_q <= 3'h0;
            rc_q <= 3'h0;
            cap_s1_q <= '0;
            cap_s2_q <= '0;
        end else begin
            sclk_q <= sclk_d;
            st_q <= st_d;
            addr_q <= addr_d;
            beat_q <= beat_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            lastrd_q <= lastrd_d;
            cs_n_q <= cs_n_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
            wd_q <= wd_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
            rdy_q <= rdy_d;
            exp_q <= exp_d;
            // both return clock edges mark a beat, captured in two stages
            rc_q <= {rc_q[1:0], sram_return_clock}; // RQ21 RQ1 RQ2
            cap_s1_q <= sram_data_bus_i;
            cap_s2_q <= cap_s1_q;
        end
    end

    // beat written when a synchronised return clock edge is seen
    assign fifo_in_v = (rc_q[2] != rc_q[1]) && exp_q != 3'h0;

    l3si_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(fifo_in_v),
        .in_ready(fifo_in_rdy),
        .in_data(cap_s2_q),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    always_comb begin
        sram_output_clock = sclk_q;
        sram_return_clock_out = sclk_q; // RQ12
        sram_addr = addr_q;
        sram_control_zero = cs_n_q; // RQ11
        sram_control_one = we_n_q; // RQ10
        sram_double_xfer = (mode == L3SI_MODE_DDR); // RQ4
        sram_data_bus_o = wd_q;
        sram_data_bus_oe_n = oe_n_q;
        req_ready = rdy_q;
    end

    a_cs_low_ctl: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == L3SI_ADDR && sedge) |=> !sram_control_zero) // RQ11
        else $error("chip select not asserted during address beat");
    a_we_write: assert property (@(posedge clk_sys) disable iff (rst)
        (!sram_control_one) |-> !sram_control_zero) // RQ10
        else $error("write strobe without chip select");
    a_turn_off: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == L3SI_TURN) |=> sram_data_bus_oe_n) // RQ17
        else $error("driving bus in turnaround");
    a_xtra_read: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == L3SI_XTRA && sedge) |=> (!sram_control_zero &&
        sram_control_one)) // RQ16
        else $error("extra read cycle missing");
    a_no_xtra_lw: assert property (@(posedge clk_sys) disable iff (rst)
        (mode == L3SI_MODE_LW) |-> st_q != L3SI_XTRA) // RQ9
        else $error("extra read in late write mode");
    a_lw_data: assert property (@(posedge clk_sys) disable iff (rst)
        (mode == L3SI_MODE_LW && $fell(sram_control_one)) |->
        ##[1:3] !sram_data_bus_oe_n) // RQ5
        else $error("late write data missing");
    a_addr_step: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == L3SI_ADDR && sedge && beat_q != 2'h0) |=>
        sram_addr == $past(sram_addr) + 1'b1) // RQ6
        else $error("address not advanced per beat");
    a_ddr_double: assert property (@(posedge clk_sys) disable iff (rst)
        (mode == L3SI_MODE_DDR) |-> sram_double_xfer) // RQ4
        else $error("double transfer not selected");
    a_ret_loop: assert property (@(posedge clk_sys) disable iff (rst)
        sram_return_clock_out == sram_output_clock) // RQ12
        else $error("return clock output not looped");
    a_read_done: assert property (@(posedge clk_sys) disable iff (rst)
        (exp_q != 3'h0 && st_q == L3SI_IDLE) |-> !req_ready) // RQ18
        else $error("new request before read completed");
    // bounded by the longest line: four beats in flight
    a_exp_bound: assert property (@(posedge clk_sys) disable iff (rst) // RQ18
        exp_q <= 3'h4)
        else $error("outstanding read count overflow");
    a_pb_wdata: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
        (mode == L3SI_MODE_PB && $fell(sram_control_one)) |->
        !sram_data_bus_oe_n)
        else $error("burst write data not with command");
    a_lw_late: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
        (mode == L3SI_MODE_LW && $fell(sram_control_one)) |->
        sram_data_bus_oe_n)
        else $error("late write data driven with command");
    a_wait_desel: assert property (@(posedge clk_sys) disable iff (rst) // RQ14
        (st_q == L3SI_WAIT && sedge) |=>
        sram_control_zero)
        else $error("no deselect after extra read");
endmodule

// ==== l3si_sram_model.sv ====
// l3si_sram_model: behavioural sram bank facing the l3si controller
// assumes pins are sampled on the clk_sys edge where the sram clock rises
module l3si_sram_model import l3si_pkg::*; (
    // clock and mode
    input wire logic clk_sys,
    input wire logic [1:0] mode,
    input wire logic sram_output_clock,
    // sram pins
    input wire logic [17:0] sram_addr,
    input wire logic sram_control_zero,
    input wire logic sram_control_one,
    input wire logic [63:0] sram_data_bus_o,
    output logic [63:0] sram_data_bus_i,
    output logic sram_return_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] mem [logic [17:0]];
    logic [63:0] words [$];
    logic [63:0] q_data;
    logic [17:0] q_addr;
    logic q_vld = 1'b0;
    logic cap = 1'b0;
    int beat = 0;

    function automatic logic [63:0] rdval(logic [17:0] a, logic h);
        if (q_vld && a == q_addr) return q_data;
        if (mem.exists(a)) return mem[a];
        return {45'h0a5c3, h, a};
    endfunction

    always @(posedge clk_sys) begin
        if (!sram_output_clock) begin
            if (cap) begin
                q_data = sram_data_bus_o;
                q_vld = 1'b1;
                cap = 1'b0;
            end
            if (sram_control_zero) begin
                beat = 0;
            end else if (!sram_control_one) begin
                if (mode == L3SI_MODE_PB) begin
                    mem[sram_addr] = sram_data_bus_o;
                end else begin
                    if (q_vld) mem[q_addr] = q_data;
                    q_addr = sram_addr;
                    q_vld = 1'b0;
                    cap = 1'b1;
                end
            end else begin
                // the extra read strobe after a line returns no word
                if (!(mode == L3SI_MODE_PB && beat >= L3SI_BEATS)) begin
                    words.push_back(rdval(sram_addr, 1'b0));
                    if (mode == L3SI_MODE_DDR)
                        words.push_back(rdval(sram_addr, 1'b1));
                end
                beat++;
            end
        end
    end

    // odd delays keep return edges off clk_sys edges
    initial begin
        sram_return_clock = 1'b0;
        sram_data_bus_i = '0;
        forever begin
            wait (words.size() > 0);
            sram_data_bus_i = words.pop_front();
            #13 sram_return_clock = ~sram_return_clock;
            #67;
            // released bus shows no stale word
            if (words.size() == 0) sram_data_bus_i = ~sram_data_bus_i;
        end
    end
endmodule

// ==== testbench.sv ====
// testbench: self-checking bench for l3si_ctrl with a model sram bank
// assumes the sram model answers every read beat on its return clock
module testbench import l3si_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst, req_valid, req_ready, req_write, rd_valid, rd_ready;
    logic [1:0] mode;
    logic [17:0] req_addr, sram_addr;
    logic [63:0] req_wdata, rd_data, bus_i, bus_o;
    logic oclk, cs_n, we_n, dbl, oe_n, rclk, rclk_out;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cs_cnt, oe_bad, waited;

    l3si_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .mode(mode),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .sram_output_clock(oclk),
        .sram_addr(sram_addr), .sram_control_zero(cs_n),
        .sram_control_one(we_n), .sram_double_xfer(dbl),
        .sram_data_bus_i(bus_i), .sram_data_bus_o(bus_o),
        .sram_data_bus_oe_n(oe_n), .sram_return_clock(rclk),
        .sram_return_clock_out(rclk_out));

    l3si_sram_model sram_u (.clk_sys(clk_sys), .mode(mode),
        .sram_output_clock(oclk), .sram_addr(sram_addr),
        .sram_control_zero(cs_n), .sram_control_one(we_n),
        .sram_data_bus_o(bus_o), .sram_data_bus_i(bus_i),
        .sram_return_clock(rclk));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (!oclk && cs_n === 1'b0) cs_cnt++;
        if (oe_n !== 1'b1) oe_bad++;
    end

    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task report_and_stop;
        $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic timeout;
        n_mismatch++;
        $display("ERROR handshake expected 1 seen 0");
        report_and_stop();
    endtask

    task automatic req(logic w, logic [17:0] a, logic [63:0] d);
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        waited = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clk_sys);
            waited++;
            if (waited > 2000) timeout();
        end
        req_valid = 1'b0;
        // write data is sampled per address beat, so it stands until the
        // last beat of the line has gone out
        if (w) repeat (8) @(negedge clk_sys);
    endtask

    // leaves rd_ready high; only the stall scenario lowers it
    task automatic drain(logic [17:0] a, logic ddr, logic wr, logic [63:0] d);
        logic [63:0] e;
        int t;
        rd_ready = 1'b1;
        for (int k = 0; k < 4; k++) begin
            t = 0;
            while (rd_valid !== 1'b1) begin
                @(negedge clk_sys);
                t++;
                if (t > 2000) timeout();
            end
            e = ddr ? {45'h0a5c3, k[0], a + 18'(k / 2)}
                    : {45'h0a5c3, 1'b0, a + 18'(k)};
            chk("rd_data", rd_data, wr ? d : e);
            @(negedge clk_sys);
        end
    endtask

    task automatic t_reset;
        chk("cs_n", cs_n, 1'b1);
        chk("we_n", we_n, 1'b1);
        chk("oe_n", oe_n, 1'b1);
        chk("addr", sram_addr, '0);
        chk("req_ready", req_ready, 1'b0);
        chk("rd_valid", rd_valid, 1'b0);
        chk("clk_loop", rclk_out, oclk);
    endtask

    task automatic t_read(logic [1:0] m, logic [17:0] a);
        @(negedge clk_sys);
        mode = m;
        cs_cnt = 0;
        oe_bad = 0;
        @(negedge clk_sys);
        chk("double_xfer", dbl, m == L3SI_MODE_DDR);
        req(1'b0, a, '0);
        drain(a, m == L3SI_MODE_DDR, 1'b0, '0);
        chk("cs_beats", cs_cnt, m == L3SI_MODE_DDR ? 2 :
            m == L3SI_MODE_LW ? 4 : 5);
        chk("oe_n_read", oe_bad, 0);
    endtask

    task automatic t_wr_rd(logic [1:0] m, logic [17:0] a);
        logic [63:0] d1, d2;
        d1 = {62'h0c0de5a5a1234567, m};
        d2 = ~d1;
        @(negedge clk_sys);
        mode = m;
        req(1'b1, a, d1);
        req(1'b1, a + 18'h4, d2);
        req(1'b0, a, '0);
        drain(a, 1'b0, 1'b1, d1);
        req(1'b0, a + 18'h4, '0);
        drain(a + 18'h4, 1'b0, 1'b1, d2);
    endtask

    task automatic t_full(logic [17:0] a);
        @(negedge clk_sys);
        rd_ready = 1'b0;
        req(1'b0, a, '0);
        req(1'b0, a + 18'h4, '0);
        fork
            req(1'b0, a + 18'h8, '0);
            begin
                repeat (120) @(negedge clk_sys);
                drain(a, 1'b0, 1'b0, '0);
                drain(a + 18'h4, 1'b0, 1'b0, '0);
            end
        join
        chk("full_refused", waited >= 100, 1'b1);
        drain(a + 18'h8, 1'b0, 1'b0, '0);
        @(negedge clk_sys);
        chk("fifo_empty", rd_valid, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        mode = L3SI_MODE_DDR;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        rd_ready = 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_read(L3SI_MODE_DDR, 18'h3fff0);
        t_read(L3SI_MODE_LW, 18'h3fff8);
        t_read(L3SI_MODE_PB, 18'h00010);
        t_wr_rd(L3SI_MODE_LW, 18'h20000);
        t_wr_rd(L3SI_MODE_PB, 18'h10000);
        t_full(18'h00100);
        report_and_stop();
    end
endmodule
